//--- logic/vrm_ctrl.sv
// slot-0 side controller: software orders one bus cycle through avalon-mm
// registers, waits for acknowledge or timeout. assumes slave on same clock.
`default_nettype none
`include "vrm_regs.svh"
module vrm_ctrl
  import vrm_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  vrm_bus_if.ctl           bus,
  input  wire logic [2:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest
);

  logic       acc_q;
  logic       acc;
  vrm_state_e state_q;
  logic [23:0] addr_q;
  logic [31:0] wdata_q;
  logic [31:0] rdata_q;
  logic [2:0]  mode_q;
  logic        done_q;
  logic        tmo_q;
  logic [8:0]  tmo_cnt_q;
  logic        go;
  logic        fin_ok;
  logic        fin_tmo;

  // one wait state per access
  assign avs_waitrequest = (avs_read || avs_write) && !acc_q;
  assign acc = (avs_read || avs_write) && !acc_q;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      acc_q <= 1'b0;
    end else begin
      acc_q <= acc;
    end
  end

  assign go = acc_q && avs_write && avs_address == `VRM_AV_CTRL
              && avs_writedata[`VRM_CT_GO] && state_q == VRM_IDLE;
  assign fin_ok  = state_q == VRM_CYCLE && bus.ack;
  assign fin_tmo = state_q == VRM_CYCLE && !bus.ack
                   && tmo_cnt_q == 9'(`VRM_TMO_CYCLES - 1);

  // software registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      addr_q  <= 24'h00_0000;
      wdata_q <= 32'h0000_0000;
      mode_q  <= 3'h0;
    end else if (acc_q && avs_write && state_q == VRM_IDLE) begin
      if (avs_address == `VRM_AV_ADDR) begin
        addr_q <= avs_writedata[23:0];
      end
      if (avs_address == `VRM_AV_WDATA) begin
        wdata_q <= avs_writedata;
      end
      if (avs_address == `VRM_AV_CTRL) begin
        mode_q <= avs_writedata[`VRM_CT_LWORD:`VRM_CT_WE];
      end
    end
  end

  // cycle sequencer
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q   <= VRM_IDLE;
      tmo_cnt_q <= 9'h000;
      rdata_q   <= 32'h0000_0000;
    end else begin
      case (state_q)
        VRM_IDLE: begin
          tmo_cnt_q <= 9'h000;
          if (go) begin
            state_q <= VRM_CYCLE;
          end
        end
        VRM_CYCLE: begin
          tmo_cnt_q <= tmo_cnt_q + 9'h001;
          if (fin_ok) begin
            rdata_q <= bus.rdata;
            state_q <= VRM_IDLE;
          end else if (fin_tmo) begin
            state_q <= VRM_IDLE;
          end
        end
        default: state_q <= VRM_IDLE;
      endcase
    end
  end

  // sticky flags, write one to clear; a new event wins over the clear
  logic clr;
  assign clr = acc_q && avs_write && avs_address == `VRM_AV_STATUS;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      done_q <= 1'b0;
      tmo_q  <= 1'b0;
    end else begin
      done_q <= fin_ok  || (done_q && !(clr && avs_writedata[`VRM_ST_DONE]));
      tmo_q  <= fin_tmo || (tmo_q && !(clr && avs_writedata[`VRM_ST_TMO]));
    end
  end

  // read data registered at the wait cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (acc && avs_read) begin
      case (avs_address)
        `VRM_AV_ADDR:   avs_readdata <= {8'h00, addr_q};
        `VRM_AV_WDATA:  avs_readdata <= wdata_q;
        `VRM_AV_CTRL:   avs_readdata <= {28'h0, mode_q, 1'b0};
        `VRM_AV_STATUS: avs_readdata <= {29'h0, tmo_q, done_q, state_q == VRM_CYCLE};
        `VRM_AV_RDATA:  avs_readdata <= rdata_q;
        default:        avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  assign bus.stb   = state_q == VRM_CYCLE;
  assign bus.addr  = addr_q;
  assign bus.wdata = wdata_q;
  assign bus.we    = mode_q[0];
  assign bus.a24   = mode_q[1];
  assign bus.lword = mode_q[2];

endmodule // vrm_ctrl
`default_nettype wire

//--- logic/vrm_slave.sv
// register-based matrix slave: a16 config registers, a24 relay registers,
// relay drive with break-before-make. assumes bus master on the same clock,
// switches and option strap are asynchronous pins.
//
// How it works
// - each channel drives at most one path
// - eight channels per matrix, a and b sides
// - up to eight pairings closed together
// - second matrix independent, when fitted
// - switch address 1 to ff, zero unused
// - switch ff selects dynamic configuration
// - static address ignores writes from manager
// - dynamic address adopts manager's written value
// - lamp pulses when addressed, else off
// - interrupt level in 3eh register bits
// - interrupt level resets to none
// - a16 space: 32 sixteen-bit registers
// - only five registers implemented
// - only manager writes configuration registers
// - a16 accepts sixteen-bit transfers only
// - a24 accepts sixteen and 32-bit transfers
// - config in a16, relays in a24
// - a16 base is address shl 6 or c000
// - register control only, no word serial
// - a24 base from offset register top byte
// - a24 window spans 64 kbytes
//
// The implementer's own choices: the register offsets and the Avalon-MM register port.
`default_nettype none
`include "vrm_regs.svh"
module vrm_slave
  import vrm_pkg::*;
#(
  parameter int unsigned LED_CYCLES = `VRM_LED_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  vrm_bus_if.dev           bus,
  input  wire logic [3:0]  address_switch_low,
  input  wire logic [3:0]  address_switch_high,
  input  wire logic        dual_fitted,
  output logic [63:0]      relay_drive,
  output logic [2:0]       irq_level,
  output logic [7:0]       logical_addr,
  output logic             bus_led,
  output logic             power_indicator
);

  // two-flop synchronisers for the pins
  logic [8:0] pin_s1_q;
  logic [8:0] pin_s2_q;
  always_ff @(posedge clk) begin
    pin_s1_q <= {dual_fitted, address_switch_high, address_switch_low};
    pin_s2_q <= pin_s1_q;
  end

  // logical address captured after reset release
  logic       init_q;
  logic       dyn_q;
  logic       dual_q;
  logic [7:0] la_q;
  logic       take;
  logic       hit16;
  logic       hit24;
  logic [4:0] a16_idx;
  logic [15:0] off_q;
  logic        a24en_q;
  logic [1:0]  ctl_lo_q;
  logic [2:0]  irq_q;
  logic [31:0] mat_q [2];
  logic        ack_q;
  logic [31:0] rdata_q;

  assign a16_idx = bus.addr[5:1];

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      init_q <= 1'b0;
      dyn_q  <= 1'b0;
      dual_q <= 1'b0;
      la_q   <= `VRM_LA_RESERVED;
    end else if (!init_q) begin
      init_q <= 1'b1;
      la_q   <= pin_s2_q[7:0];
      dyn_q  <= (pin_s2_q[7:0] == `VRM_LA_DYNAMIC);
      dual_q <= pin_s2_q[8];
    end else if (take && hit16 && bus.we && a16_idx == `VRM_OFF_ID && dyn_q) begin
      la_q <= bus.wdata[7:0];
    end
  end

  // address decode; a16 takes only 16-bit transfers
  always_comb begin
    hit16 = !bus.a24 && init_q && la_q != `VRM_LA_RESERVED && !bus.lword
            && bus.addr[15:6] == {`VRM_A16_TOP, la_q};
    hit24 = bus.a24 && a24en_q && bus.addr[23:16] == off_q[15:8];
  end

  // accept once per strobe; the ack pulse blocks a second take
  assign take = bus.stb && !ack_q && (hit16 || hit24);

  // configuration and device-dependent registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      off_q    <= 16'h0000;
      a24en_q  <= 1'b0;
      ctl_lo_q <= 2'b00;
      irq_q    <= `VRM_IRQ_NONE;
    end else if (take && hit16 && bus.we) begin
      case (a16_idx)
        `VRM_OFF_STATCTL: begin
          a24en_q  <= a24en_q | bus.wdata[`VRM_SC_A24EN]; // stays set once set
          ctl_lo_q <= bus.wdata[1:0];
        end
        `VRM_OFF_OFFSET: off_q <= bus.wdata[15:0];
        `VRM_OFF_MATCTL: irq_q <= bus.wdata[2:0];
        default: ;
      endcase
    end
  end

  // relay selection registers, 3-bit code per channel in each nibble
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mat_q[0] <= 32'h0000_0000;
      mat_q[1] <= 32'h0000_0000;
    end else if (take && hit24 && bus.we) begin
      if ({bus.addr[15:3], 3'b000} == `VRM_A24_MAT0) begin
        if (bus.lword || !bus.addr[1]) begin
          if (bus.addr[2] == 1'b0) begin
            mat_q[0][15:0] <= bus.wdata[15:0];
          end else if (dual_q) begin
            mat_q[1][15:0] <= bus.wdata[15:0];
          end
        end
        if (bus.lword || bus.addr[1]) begin
          if (bus.addr[2] == 1'b0) begin
            mat_q[0][31:16] <= bus.lword ? bus.wdata[31:16] : bus.wdata[15:0];
          end else if (dual_q) begin
            mat_q[1][31:16] <= bus.lword ? bus.wdata[31:16] : bus.wdata[15:0];
          end
        end
      end
    end
  end

  // read mux and acknowledge, one cycle after take
  logic [31:0] rd_d;
  logic [31:0] mat_rd;
  always_comb begin
    mat_rd = bus.addr[2] ? (dual_q ? mat_q[1] : 32'h0000_0000) : mat_q[0];
    rd_d   = 32'h0000_0000;
    if (hit16) begin
      case (a16_idx)
        `VRM_OFF_ID:      rd_d = {16'h0000, `VRM_CLASS_REG, `VRM_SPACE_A16_A24, `VRM_MFR_ID};
        `VRM_OFF_DEVTYPE: rd_d = {16'h0000, `VRM_MEM_64K_A24, `VRM_MODEL_CODE};
        `VRM_OFF_STATCTL: rd_d = {16'h0000, a24en_q, 1'b1, 10'h3ff, 2'b11, ctl_lo_q};
        `VRM_OFF_OFFSET:  rd_d = {16'h0000, off_q};
        `VRM_OFF_MATCTL:  rd_d = {29'h0, irq_q};
        default:          rd_d = 32'h0000_0000;
      endcase
    end else if ({bus.addr[15:3], 3'b000} == `VRM_A24_MAT0) begin
      if (bus.lword) begin
        rd_d = mat_rd;
      end else begin
        rd_d = {16'h0000, bus.addr[1] ? mat_rd[31:16] : mat_rd[15:0]};
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      ack_q <= take;
      if (take) begin
        rdata_q <= rd_d;
      end
    end
  end

  // bus lamp stretch
  logic [$clog2(LED_CYCLES+1)-1:0] led_cnt_q;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      led_cnt_q <= '0;
    end else if (take) begin
      led_cnt_q <= ($clog2(LED_CYCLES+1))'(LED_CYCLES);
    end else if (led_cnt_q != '0) begin
      led_cnt_q <= led_cnt_q - 1'b1;
    end
  end

  // relay drive: decode code to one path, open before changing path
  genvar g;
  generate
    for (g = 0; g < 16; g++) begin : g_chan
      vrm_onehot_t want;
      vrm_onehot_t cur_q;
      logic [2:0]  code;
      assign code = mat_q[g / 8][(g % 8) * 4 +: 3];
      always_comb begin
        case (code)
          3'h1:    want = 4'h1;
          3'h2:    want = 4'h2;
          3'h3:    want = 4'h4;
          3'h4:    want = 4'h8;
          default: want = 4'h0;
        endcase
      end
      always_ff @(posedge clk) begin
        if (sys_rst) begin
          cur_q <= 4'h0;
        end else if (cur_q != 4'h0 && cur_q != want) begin
          cur_q <= 4'h0;
        end else begin
          cur_q <= want;
        end
      end
      assign relay_drive[g*4 +: 4] = cur_q;
    end
  endgenerate

  assign bus.ack         = ack_q;
  assign bus.rdata       = rdata_q;
  assign irq_level       = irq_q;
  assign logical_addr    = la_q;
  assign bus_led         = (led_cnt_q != '0);
  assign power_indicator = init_q;

endmodule // vrm_slave
`default_nettype wire

//--- pkg/vrm_bus_if.sv
// backplane bus between controller and matrix slave
// one clock shared by both ends; the bench instantiates and joins them
`default_nettype none
interface vrm_bus_if;
  logic        stb;
  logic        a24;
  logic [23:0] addr;
  logic        we;
  logic        lword;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic        ack;
  modport dev (input stb, input a24, input addr, input we, input lword, input wdata,
               output rdata, output ack);
  modport ctl (output stb, output a24, output addr, output we, output lword,
               output wdata, input rdata, input ack);
endinterface
`default_nettype wire

//--- pkg/vrm_pkg.sv
// types shared by the matrix slave and its controller
// assumes nothing beyond the regs header
`default_nettype none
package vrm_pkg;
  typedef enum logic [0:0] {
    VRM_IDLE  = 1'b0,
    VRM_CYCLE = 1'b1
  } vrm_state_e;
  typedef logic [3:0] vrm_onehot_t;  // one relay channel, one bit per path
endpackage
`default_nettype wire

//--- pkg/vrm_regs.svh
// offsets, field positions, reset values and timing counts of the matrix slave
// and its controller; included by bare name, definitions only
`ifndef VRM_REGS_SVH
`define VRM_REGS_SVH

`define VRM_CLK_HZ           40000000
// a16 window: logical address << 6 | c000
`define VRM_A16_TOP          2'b11
`define VRM_OFF_ID           5'h00
`define VRM_OFF_DEVTYPE      5'h01
`define VRM_OFF_STATCTL      5'h02
`define VRM_OFF_OFFSET       5'h03
`define VRM_OFF_MATCTL       5'h1f
// id register fields; manufacturer code value is arbitrary
`define VRM_CLASS_REG        2'b11
`define VRM_SPACE_A16_A24    2'b00
`define VRM_MFR_ID           12'h5a5
// device type fields; model code value is arbitrary
`define VRM_MEM_64K_A24      4'h7
`define VRM_MODEL_CODE       12'h3c3
// status/control bits
`define VRM_SC_A24EN         15
`define VRM_LA_DYNAMIC       8'hff
`define VRM_LA_RESERVED      8'h00
// a24 relay registers (offset within 64 kbyte window)
`define VRM_A24_MAT0         16'h8000
`define VRM_A24_MAT1         16'h8004
`define VRM_IRQ_NONE         3'h0
// bus activity lamp stretch, in microseconds
`define VRM_LED_US           1000
`define VRM_LED_CYCLES       ((`VRM_LED_US * (`VRM_CLK_HZ / 1000000)))
// controller registers (avalon word index)
`define VRM_AV_ADDR          3'h0
`define VRM_AV_WDATA         3'h1
`define VRM_AV_CTRL          3'h2
`define VRM_AV_STATUS        3'h3
`define VRM_AV_RDATA         3'h4
`define VRM_CT_GO            0
`define VRM_CT_WE            1
`define VRM_CT_A24           2
`define VRM_CT_LWORD         3
`define VRM_ST_BUSY          0
`define VRM_ST_DONE          1
`define VRM_ST_TMO           2
// bus cycle timeout, in nanoseconds
`define VRM_TMO_NS           10000
`define VRM_TMO_CYCLES       ((`VRM_TMO_NS / 25))

`endif

//--- tb/tb_top.sv
// self-checking bench: controller and slave joined by the bus
// assumes design files and interface are compiled first
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk;
  logic        sys_rst;
  logic [7:0]  sw;
  logic        dual_fitted;
  logic [2:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [63:0] relay_drive;
  logic [2:0]  irq_level;
  logic [7:0]  logical_addr;
  logic        bus_led;
  logic        power_indicator;
  int          num_errors;
  int          cmp_count;
  vrm_bus_if bus ();
  vrm_ctrl vrm_ctrl_inst (.clk(clk), .sys_rst(sys_rst), .bus(bus),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));
  vrm_slave #(.LED_CYCLES(8)) vrm_slave_inst (.clk(clk), .sys_rst(sys_rst), .bus(bus),
    .address_switch_low(sw[3:0]), .address_switch_high(sw[7:4]),
    .dual_fitted(dual_fitted), .relay_drive(relay_drive), .irq_level(irq_level),
    .logical_addr(logical_addr), .bus_led(bus_led), .power_indicator(power_indicator));
  vrm_monitor vrm_monitor_inst (.clk(clk), .sys_rst(sys_rst), .stb(bus.stb),
    .a24(bus.a24), .addr(bus.addr), .lword(bus.lword), .ack(bus.ack),
    .relay_drive(relay_drive), .bus_led(bus_led));
  // 40 mhz clock
  always #12.5 clk = ~clk;
  task automatic complete_run();
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one avalon access, held until waitrequest is seen low
  task automatic av(input logic wr, input logic [2:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n >= 50) begin
      num_errors++;
      $display("Error waitrequest expected 0 seen 1");
      complete_run();
    end
  endtask
  // one backplane cycle through the controller; t is the timeout flag
  task automatic vb(input logic wr, input logic a, input logic lw, input logic [23:0] ad,
                    input logic [31:0] d, output logic [31:0] q, output logic t);
    logic [31:0] s;
    int n;
    av(1'b1, 3'h0, {8'h0, ad}, s);
    av(1'b1, 3'h1, d, s);
    av(1'b1, 3'h2, {28'h0, lw, a, wr, 1'b1}, s);
    s = 32'h0;
    n = 0;
    while (s[2:1] === 2'b00 && n < 300) begin
      av(1'b0, 3'h3, 32'h0, s);
      n++;
    end
    t = s[2];
    av(1'b0, 3'h4, 32'h0, q);
    av(1'b1, 3'h3, 32'h6, s);
    if (n >= 300) begin
      num_errors++;
      $display("Error bus done expected 1 seen 0");
      complete_run();
    end
  endtask
  task automatic do_reset(input logic [7:0] s, input logic d);
    sys_rst <= 1'b1;
    sw <= s;
    dual_fitted <= d;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  // expected channel drive from a relay word: codes 1..4 close one path
  function automatic logic [31:0] drv(input logic [31:0] w);
    logic [31:0] r;
    r = 32'h0;
    for (int k = 0; k < 8; k++)
      if (w[4*k+:3] inside {[3'h1:3'h4]}) r[4*k+:4] = 4'h1 << (w[4*k+:3] - 3'h1);
    return r;
  endfunction
  initial begin
    logic [31:0] q;
    logic [31:0] w;
    logic [31:0] e;
    logic        t;
    logic [7:0]  la;
    logic [7:0]  ob;
    logic [15:0] bs;
    logic [15:0] ofs [3];
    logic [15:0] exv [3];
    clk = 1'b0;
    ofs = '{16'h0, 16'h2, 16'h10};
    exv = '{16'hc5a5, 16'h73c3, 16'h0};
    avs_address = 3'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    num_errors = 0;
    cmp_count = 0;
    void'($urandom(32'ha7bf));
    la = 8'($urandom_range(254, 1));
    ob = 8'($urandom);
    bs = {2'b11, la, 6'h0};
    do_reset(la, 1'b1);
    check("relays", 64'h0, relay_drive);
    check("irq", 64'h0, 64'(irq_level));
    check("la", 64'(la), 64'(logical_addr));
    check("power", 64'h1, 64'(power_indicator));
    $display("reset test done");
    for (int i = 0; i < 3; i++) begin
      vb(1'b0, 1'b0, 1'b0, {8'h0, bs | ofs[i]}, 32'h0, q, t);
      check("a16 read", 64'(exv[i]), 64'(q[15:0]));
    end
    vb(1'b1, 1'b0, 1'b0, {8'h0, bs}, {24'h0, ~la}, q, t);
    check("static la", 64'(la), 64'(logical_addr));
    w = 32'($urandom_range(7, 1));
    vb(1'b1, 1'b0, 1'b0, {8'h0, bs | 16'h3e}, w, q, t);
    check("irq level", 64'(w[2:0]), 64'(irq_level));
    vb(1'b0, 1'b0, 1'b0, {8'h0, bs | 16'h3e}, 32'h0, q, t);
    check("irq read", 64'(w[2:0]), 64'(q[2:0]));
    $display("register test done");
    vb(1'b0, 1'b0, 1'b1, {8'h0, bs}, 32'h0, q, t);
    check("a16 long", 64'h1, 64'(t));
    vb(1'b0, 1'b0, 1'b0, {10'h3, la ^ 8'h1, 6'h0}, 32'h0, q, t);
    check("other la", 64'h1, 64'(t));
    vb(1'b1, 1'b1, 1'b0, {ob, 16'h8000}, 32'h1, q, t);
    check("a24 off", 64'h1, 64'(t));
    $display("refusal test done");
    vb(1'b1, 1'b0, 1'b0, {8'h0, bs | 16'h4}, 32'h8000, q, t);
    vb(1'b1, 1'b0, 1'b0, {8'h0, bs | 16'h6}, {16'h0, ob, 8'h0}, q, t);
    vb(1'b0, 1'b1, 1'b0, {ob, 16'hfffe}, 32'h0, q, t);
    check("window top", 64'h0, {q[15:0], 15'h0, t});
    e = 32'h0;
    for (int i = 0; i < 6; i++) begin
      w = $urandom;
      if (i[0]) begin
        vb(1'b1, 1'b1, 1'b1, {ob, 16'h8000}, w, q, t);
        e = w;
      end else begin
        vb(1'b1, 1'b1, 1'b0, {ob, 16'h8002}, {16'h0, w[15:0]}, q, t);
        e = {w[15:0], e[15:0]};
      end
      check("matrix0", {32'h0, drv(e)}, relay_drive);
    end
    w = 32'h43214321;
    vb(1'b1, 1'b1, 1'b1, {ob, 16'h8004}, w, q, t);
    check("matrix1", {drv(w), drv(e)}, relay_drive);
    $display("relay test done");
    w = 32'($urandom_range(254, 1));
    do_reset(8'hff, 1'b0);
    check("dyn la", 64'hff, 64'(logical_addr));
    check("relays", 64'h0, relay_drive);
    vb(1'b1, 1'b0, 1'b0, 24'h00ffc0, w, q, t);
    check("dyn set", 64'(w[7:0]), 64'(logical_addr));
    vb(1'b0, 1'b0, 1'b0, {10'h3, w[7:0], 6'h0}, 32'h0, q, t);
    check("dyn read", 64'h0c5a5, {t, q[15:0]});
    vb(1'b1, 1'b0, 1'b0, {10'h3, w[7:0], 6'h4}, 32'h8000, q, t);
    vb(1'b1, 1'b1, 1'b1, 24'h008004, 32'h43214321, q, t);
    check("single relays", 64'h0, relay_drive);
    vb(1'b0, 1'b1, 1'b1, 24'h008004, 32'h0, q, t);
    check("single matrix1", 64'h0, {q, 31'h0, t});
    $display("dynamic test done");
    complete_run();
  end
endmodule // tb_top
`default_nettype wire

//--- tb/vrm_monitor.sv
// bus and relay checker for the matrix slave
// assumes one clock, reset synchronous active high
`default_nettype none
`include "vrm_regs.svh"
module vrm_monitor (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        stb,
  input wire logic        a24,
  input wire logic [23:0] addr,
  input wire logic        lword,
  input wire logic        ack,
  input wire logic [63:0] relay_drive,
  input wire logic        bus_led
);
  timeunit 1ns;
  timeprecision 1ps;
  // cycles the current request has stood; the controller gives up at its timeout
  logic [8:0] stb_cnt_q;
  always_ff @(posedge clk) begin
    if (sys_rst || !stb) begin
      stb_cnt_q <= 9'h000;
    end else begin
      stb_cnt_q <= stb_cnt_q + 9'h001;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // acknowledge shape and cause
  chk_ack_pulse: assert property (ack |=> !ack)
    else $error("ack longer than one cycle");
  chk_ack_cause: assert property (ack |-> stb && $past(stb))
    else $error("ack without a held request");
  chk_req_hold: assert property (stb && !ack && stb_cnt_q != 9'(`VRM_TMO_CYCLES - 1)
    |=> stb && $stable(addr) && $stable(a24))
    else $error("request changed before ack");
  chk_stb_drop: assert property (ack |=> !stb)
    else $error("request held after ack");
  // a16 answers only word transfers in its base region
  chk_a16_word: assert property (ack && !a24 |-> !lword)
    else $error("a16 long transfer answered");
  chk_a16_base: assert property (ack && !a24 |-> addr[15:14] == 2'b11)
    else $error("a16 answer outside c000 region");
  // activity lamp follows accepted accesses
  chk_led_on: assert property (ack |-> bus_led)
    else $error("lamp off while addressed");
  chk_led_cause: assert property ($rose(bus_led) |-> ack)
    else $error("lamp lit without access");
  chk_reset_open: assert property ($past(sys_rst) |-> relay_drive == 64'h0)
    else $error("relay closed after reset");
  // per channel: one path at most, open between two paths
  for (genvar g = 0; g < 16; g++) begin : g_ch
    chk_one_path: assert property ($onehot0(relay_drive[4*g+:4]))
      else $error("two paths closed on one channel");
    chk_break_make: assert property (relay_drive[4*g+:4] != 4'h0 &&
      $past(relay_drive[4*g+:4]) != 4'h0 |-> $stable(relay_drive[4*g+:4]))
      else $error("path changed without open cycle");
  end
endmodule // vrm_monitor
`default_nettype wire
